// >>> inc/cms_defines.svh
// Offsets, reset values and field positions of the comparator input selects.
// Assumes inclusion by bare name from the design.
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH

// Special function addresses, byte offsets on the register bus
`define CMS_ONE_SEL_OFFSET 8'h9E
`define CMS_ZERO_SEL_OFFSET 8'h9F
`define CMS_SEL_PAGE 4'h0
`define CMS_SEL_RESET 8'hFF
`define CMS_NEG_MSB 7
`define CMS_NEG_LSB 4
`define CMS_POS_MSB 3
`define CMS_POS_LSB 0

`endif

// >>> inc/cms_pkg.sv
// Types for the comparator input select bank.
// Assumes cms_defines.svh on the include path.
package cms_pkg;

  // One-hot source choice for a single comparator input
  typedef struct packed {
    logic [7:0] pin;
    logic touch_ref;
    logic half_supply;
    logic digital_supply;
    logic battery_supply;
    logic main_supply;
    logic ground;
  } cms_route_t;

  // Avalon-MM slave request
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } cms_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } cms_av_rsp_t;

  typedef enum logic [1:0] {
    CMS_IDLE = 2'b01,
    CMS_DONE = 2'b10
  } cms_state_t;

endpackage : cms_pkg

// >>> design/cms_select_bank.sv
// Two comparator input select registers and their source decoders.
// Assumes an Avalon-MM master on sys_clk, byte addressing, page fixed.
//
// The implementer's own choice: register access over Avalon-MM.
`include "cms_defines.svh"

module cms_select_bank (
  input wire logic sys_clk,
  input wire logic reset,
  input wire cms_pkg::cms_av_req_t av_req,
  output cms_pkg::cms_av_rsp_t av_rsp,
  output cms_pkg::cms_route_t comp_zero_negative_source,
  output cms_pkg::cms_route_t comp_zero_positive_source,
  output cms_pkg::cms_route_t comp_one_negative_source,
  output cms_pkg::cms_route_t comp_one_positive_source
);

  // Negative field: pins 0..6 are P0.1,3,5,7,P1.1,3,5 (index bits 0..6)
  function automatic cms_pkg::cms_route_t neg_decode(input logic [3:0] code);
    cms_pkg::cms_route_t r;
    r = '0;
    case (code)
      4'h0: r.pin[0] = 1'b1;
      4'h1: r.pin[1] = 1'b1;
      4'h2: r.pin[2] = 1'b1;
      4'h3: r.pin[3] = 1'b1;
      4'h4: r.pin[4] = 1'b1;
      4'h5: r.pin[5] = 1'b1;
      4'h6: r.pin[6] = 1'b1;
      4'hC: r.touch_ref = 1'b1;
      4'hD: r.half_supply = 1'b1;
      4'hE: r.digital_supply = 1'b1;
      4'hF: r.ground = 1'b1;
      // Reserved codes open every switch
      default: r = '0;
    endcase
    return r;
  endfunction : neg_decode

  // Positive field: pins 0..7 are P0.0,2,4,6,P1.0,2,4,6
  function automatic cms_pkg::cms_route_t pos_decode(input logic [3:0] code);
    cms_pkg::cms_route_t r;
    r = '0;
    case (code)
      4'h0: r.pin[0] = 1'b1;
      4'h1: r.pin[1] = 1'b1;
      4'h2: r.pin[2] = 1'b1;
      4'h3: r.pin[3] = 1'b1;
      4'h4: r.pin[4] = 1'b1;
      4'h5: r.pin[5] = 1'b1;
      4'h6: r.pin[6] = 1'b1;
      4'h7: r.pin[7] = 1'b1;
      4'hC: r.touch_ref = 1'b1;
      4'hD: r.half_supply = 1'b1;
      4'hE: r.battery_supply = 1'b1;
      4'hF: r.main_supply = 1'b1;
      // Reserved codes open every switch
      default: r = '0;
    endcase
    return r;
  endfunction : pos_decode

  function automatic logic [3:0] neg_field(input logic [7:0] sel);
    return sel[`CMS_NEG_MSB:`CMS_NEG_LSB];
  endfunction : neg_field

  function automatic logic [3:0] pos_field(input logic [7:0] sel);
    return sel[`CMS_POS_MSB:`CMS_POS_LSB];
  endfunction : pos_field

  // Register match on the byte address
  function automatic logic is_at(input logic [7:0] addr,
    input logic [7:0] offset);
    return addr == offset;
  endfunction : is_at

  // Bus, register and route state
  logic [7:0] zero_sel_q;
  logic [7:0] zero_sel_d;
  logic [7:0] one_sel_q;
  logic [7:0] one_sel_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  cms_pkg::cms_state_t state_q;
  cms_pkg::cms_state_t state_d;
  cms_pkg::cms_route_t z_neg_q;
  cms_pkg::cms_route_t z_neg_d;
  cms_pkg::cms_route_t z_pos_q;
  cms_pkg::cms_route_t z_pos_d;
  cms_pkg::cms_route_t o_neg_q;
  cms_pkg::cms_route_t o_neg_d;
  cms_pkg::cms_route_t o_pos_q;
  cms_pkg::cms_route_t o_pos_d;

  logic req;
  logic hit_zero;
  logic hit_one;
  logic commit;
  logic wr_zero;
  logic wr_one;

  assign req = av_req.read | av_req.write;
  assign hit_zero = is_at(av_req.address, `CMS_ZERO_SEL_OFFSET);
  assign hit_one = is_at(av_req.address, `CMS_ONE_SEL_OFFSET);

  // Write lands on the cycle in which waitrequest is low
  assign commit = (state_q == cms_pkg::CMS_DONE) && av_req.write
    && av_req.byteenable[0];
  assign wr_zero = commit && hit_zero;
  assign wr_one = commit && hit_one;

  // One wait cycle per access; read data latched while waiting
  always_comb
  begin
    state_d = state_q;
    rdata_d = rdata_q;
    case (state_q)
      cms_pkg::CMS_IDLE:
      begin
        if (req)
        begin
          state_d = cms_pkg::CMS_DONE;
          rdata_d = 32'h0000_0000;
          if (av_req.read && hit_zero)
            rdata_d[7:0] = zero_sel_q;
          if (av_req.read && hit_one)
            rdata_d[7:0] = one_sel_q;
        end
      end
      cms_pkg::CMS_DONE:
      begin
        // Master releases the request after this cycle
        state_d = cms_pkg::CMS_IDLE;
      end
      default:
      begin
        state_d = cms_pkg::CMS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_q <= cms_pkg::CMS_IDLE;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      rdata_q <= rdata_d;
    end
  end

  // Lane 0 must be enabled for a write to land
  always_comb
  begin
    zero_sel_d = zero_sel_q;
    one_sel_d = one_sel_q;
    if (wr_zero)
      zero_sel_d = av_req.writedata[7:0];
    if (wr_one)
      one_sel_d = av_req.writedata[7:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      zero_sel_q <= `CMS_SEL_RESET;
      one_sel_q <= `CMS_SEL_RESET;
    end
    else
    begin
      zero_sel_q <= zero_sel_d;
      one_sel_q <= one_sel_d;
    end
  end

  // Routes follow the registers one cycle later
  always_comb
  begin
    z_neg_d = neg_decode(neg_field(zero_sel_q));
    z_pos_d = pos_decode(pos_field(zero_sel_q));
    o_neg_d = neg_decode(neg_field(one_sel_q));
    o_pos_d = pos_decode(pos_field(one_sel_q));
  end

  // Registered routes so the analog switches see no decode glitches
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      // Same routes as the all-ones registers give
      z_neg_q <= neg_decode(neg_field(`CMS_SEL_RESET));
      z_pos_q <= pos_decode(pos_field(`CMS_SEL_RESET));
      o_neg_q <= neg_decode(neg_field(`CMS_SEL_RESET));
      o_pos_q <= pos_decode(pos_field(`CMS_SEL_RESET));
    end
    else
    begin
      z_neg_q <= z_neg_d;
      z_pos_q <= z_pos_d;
      o_neg_q <= o_neg_d;
      o_pos_q <= o_pos_d;
    end
  end

  // Waitrequest only while a request sits in the first cycle
  assign av_rsp = '{readdata: rdata_q,
    waitrequest: req && (state_q != cms_pkg::CMS_DONE)};
  assign comp_zero_negative_source = z_neg_q;
  assign comp_zero_positive_source = z_pos_q;
  assign comp_one_negative_source = o_neg_q;
  assign comp_one_positive_source = o_pos_q;

endmodule : cms_select_bank

// >>> sim/cms_select_bank_checker.sv
// Checker for the comparator input select bank.
// Assumes binding onto cms_select_bank, one clock domain.
module cms_select_bank_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire cms_pkg::cms_av_req_t av_req,
  input wire cms_pkg::cms_av_rsp_t av_rsp,
  input wire cms_pkg::cms_route_t comp_zero_negative_source,
  input wire cms_pkg::cms_route_t comp_zero_positive_source,
  input wire cms_pkg::cms_route_t comp_one_negative_source,
  input wire cms_pkg::cms_route_t comp_one_positive_source
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  function automatic logic [13:0] nf(input logic [3:0] c);
    return c < 4'h7 ? 14'h40 << c : c < 4'hC ? 14'h0 : c == 4'hF ? 14'h1
      : 14'h20 >> (c - 4'hC);
  endfunction : nf
  function automatic logic [13:0] pf(input logic [3:0] c);
    return c < 4'h8 ? 14'h40 << c : c < 4'hC ? 14'h0 : c < 4'hE
      ? 14'h20 >> (c - 4'hC) : 14'h8 >> (c - 4'hD);
  endfunction : pf
  wire logic rd = av_req.read && !av_rsp.waitrequest;
  wire logic go = av_req.write && !av_rsp.waitrequest && av_req.byteenable[0];
  wire logic wz = go && av_req.address == 8'h9F;
  wire logic wo = go && av_req.address == 8'h9E;
  wire logic [7:0] wd = av_req.writedata[7:0];
  a_zero_neg: assert property (wz |-> ##2 comp_zero_negative_source
    == nf($past(wd[7:4], 2))) else $error("zero negative route wrong");
  a_zero_pos: assert property (wz |-> ##2 comp_zero_positive_source
    == pf($past(wd[3:0], 2))) else $error("zero positive route wrong");
  a_one_neg: assert property (wo |-> ##2 comp_one_negative_source
    == nf($past(wd[7:4], 2))) else $error("one negative route wrong");
  a_one_pos: assert property (wo |-> ##2 comp_one_positive_source
    == pf($past(wd[3:0], 2))) else $error("one positive route wrong");
  a_reset_route: assert property ($fell(reset) |->
    comp_zero_negative_source == 14'h1 && comp_one_positive_source == 14'h2)
    else $error("route not at reset value");
  a_wait_first: assert property ($rose(av_req.read || av_req.write)
    |-> av_rsp.waitrequest) else $error("request answered at once");
  a_wait_once: assert property ((av_req.read || av_req.write)
    && av_rsp.waitrequest |=> !av_rsp.waitrequest) else $error("wait too long");
  a_read_empty: assert property (rd && av_req.address[7:1] != 7'h4F
    |-> av_rsp.readdata == 32'h0) else $error("unmapped read not zero");
  a_route_onehot: assert property (
    $countones(comp_zero_negative_source) <= 1
    && $countones(comp_zero_positive_source) <= 1
    && $countones(comp_one_negative_source) <= 1
    && $countones(comp_one_positive_source) <= 1)
    else $error("route selects more than one source");
  cover property (wz);
  cover property (wo);
  cover property (rd);
endmodule : cms_select_bank_checker

bind cms_select_bank cms_select_bank_checker i_chk (.sys_clk(sys_clk),
  .reset(reset), .av_req(av_req), .av_rsp(av_rsp),
  .comp_zero_negative_source(comp_zero_negative_source),
  .comp_zero_positive_source(comp_zero_positive_source),
  .comp_one_negative_source(comp_one_negative_source),
  .comp_one_positive_source(comp_one_positive_source));

// >>> sim/test_comparator_input_mux_select.sv
// Testbench: all select codes, readback, refusals, reset values.
// Assumes cms_pkg compiled and the checker bound to the design.
module test_comparator_input_mux_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0;
  logic reset = 1;
  cms_pkg::cms_av_req_t av_req = '0;
  cms_pkg::cms_av_rsp_t av_rsp;
  cms_pkg::cms_route_t zn, zp, on, op;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] q;
  typedef struct packed {
    logic [3:0] code;
    logic [13:0] neg;
    logic [13:0] pos;
  } cms_row_t;
  // One row per select code: code, negative route, positive route
  cms_row_t rows [16] = '{
    '{4'h0, 14'h0040, 14'h0040}, '{4'h1, 14'h0080, 14'h0080},
    '{4'h2, 14'h0100, 14'h0100}, '{4'h3, 14'h0200, 14'h0200},
    '{4'h4, 14'h0400, 14'h0400}, '{4'h5, 14'h0800, 14'h0800},
    '{4'h6, 14'h1000, 14'h1000}, '{4'h7, 14'h0000, 14'h2000},
    '{4'h8, 14'h0000, 14'h0000}, '{4'h9, 14'h0000, 14'h0000},
    '{4'hA, 14'h0000, 14'h0000}, '{4'hB, 14'h0000, 14'h0000},
    '{4'hC, 14'h0020, 14'h0020}, '{4'hD, 14'h0010, 14'h0010},
    '{4'hE, 14'h0008, 14'h0004}, '{4'hF, 14'h0001, 14'h0002}};
  cms_select_bank i_dut (.sys_clk(sys_clk), .reset(reset), .av_req(av_req),
    .av_rsp(av_rsp), .comp_zero_negative_source(zn),
    .comp_zero_positive_source(zp), .comp_one_negative_source(on),
    .comp_one_positive_source(op));
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 3000) results(1);
  task results(input int tmo);
    bad_count += tmo;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task chk_route(input string nm, input logic [13:0] e,
    input logic [13:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_route
  task chk_word(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  // Holds the request until waitrequest is sampled low at a rising edge
  task acc(input logic [7:0] a, input logic w, input logic [7:0] d,
    input logic [3:0] be);
    @(posedge sys_clk);
    av_req <= '{a, !w, w, {24'h0, d}, be};
    do @(posedge sys_clk); while (av_rsp.waitrequest !== 1'b0);
    q = av_rsp.readdata;
    av_req <= '0;
  endtask : acc
  task rt(input int a, input int b);
    repeat (2) @(negedge sys_clk);
    chk_route("zero neg", rows[a].neg, zn);
    chk_route("zero pos", rows[a].pos, zp);
    chk_route("one neg", rows[a].neg, on);
    chk_route("one pos", rows[b].pos, op);
  endtask : rt
  task rb(input logic [7:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00, 4'h0);
    chk_word("readback", {24'h0, e}, q);
  endtask : rb
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset <= 0;
    rt(15, 15);
    rb(8'h9F, 8'hFF);
    foreach (rows[i])
    begin
      acc(8'h9F, 1'b1, {rows[i].code, rows[i].code}, 4'h1);
      acc(8'h9E, 1'b1, {rows[i].code, ~rows[i].code}, 4'h1);
      rt(i, 15 - i);
      rb(8'h9F, {rows[i].code, rows[i].code});
      rb(8'h9E, {rows[i].code, ~rows[i].code});
    end
    acc(8'h9F, 1'b1, 8'h00, 4'h0);
    acc(8'h9D, 1'b1, 8'h00, 4'h1);
    rb(8'h9F, 8'hFF);
    rb(8'h9D, 8'h00);
    rb(8'h9E, 8'hF0);
    @(posedge sys_clk);
    reset <= 1;
    @(posedge sys_clk);
    reset <= 0;
    rt(15, 15);
    rb(8'h9E, 8'hFF);
    rb(8'h9F, 8'hFF);
    results(0);
  end
endmodule : test_comparator_input_mux_select
